// ==== rtl/ldp_top.sv ====
// low-current dimming, short check, open switchover and thermal control
`timescale 1ns/1ps
`default_nettype none
module ldp_top
(
    // clock and power-on reset
    input  wire logic                          core_clk_i,
    input  wire logic                          rst_n_i,
    // dimming pulse from the serial-pulse decoder
    input  wire logic                          dim_pulse_input_i,
    // analog indications
    input  wire ldp_pkg::ldp_led_sense_t       led_sense_i,
    input  wire logic                          therm_hot_i,
    input  wire logic                          therm_cooled_i,
    // regulator references and enables, check and thermal status
    output ldp_pkg::ldp_dim_cfg_t              dim_cfg_o,
    output logic [4:0]                         led_current_level_o,
    output logic                               dim_pwm_o,
    output logic [ldp_pkg::NUM_LED-1:0]        led_sink_output_en_o,
    output logic [ldp_pkg::NUM_LED-1:0]        negative_rail_sel_o,
    output logic                               negative_rail_pump_en_o,
    output logic                               short_check_done_o,
    output logic                               therm_shutdown_o
);
    ldp_pkg::ldp_state_t                state_reg;
    ldp_pkg::ldp_state_t                state_next;
    ldp_pkg::ldp_dim_cfg_t              cfg_reg;
    ldp_pkg::ldp_dim_cfg_t              cfg_next;
    logic [9:0]                         check_cnt_reg;
    logic [4:0]                         level_reg;
    logic                               pulse_prev_reg;
    logic                               pulse_rise;
    logic [ldp_pkg::NUM_LED-1:0]        dis_reg;
    logic [ldp_pkg::NUM_LED-1:0]        en_reg;
    logic [ldp_pkg::NUM_LED-1:0]        neg_reg;
    logic                               pump_reg;
    logic                               check_end;
    logic                               run_ok;

    assign pulse_rise = dim_pulse_input_i && !pulse_prev_reg;
    assign check_end  = (check_cnt_reg == 10'(ldp_pkg::CHECK_CYC - 1));
    assign run_ok     = (state_reg == ldp_pkg::ST_RUN) && !therm_hot_i;

    // supervisor state
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ldp_pkg::ST_CHECK:
                if (check_end)
                    state_next = therm_hot_i ? ldp_pkg::ST_THERM : ldp_pkg::ST_RUN;
            ldp_pkg::ST_RUN:
                if (therm_hot_i)
                    state_next = ldp_pkg::ST_THERM;
            ldp_pkg::ST_THERM:
                if (therm_cooled_i && !therm_hot_i)
                    state_next = ldp_pkg::ST_RUN;
            default:
                state_next = ldp_pkg::ST_CHECK;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            state_reg <= ldp_pkg::ST_CHECK;
        else
            state_reg <= state_next;
    end

    // power-up check window
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            check_cnt_reg <= 10'h000;
        else if (state_reg == ldp_pkg::ST_CHECK && !check_end)
            check_cnt_reg <= check_cnt_reg + 10'h001;
    end

    // short disable latch, sampled only in the check window
    generate
        for (genvar k = 0; k < ldp_pkg::NUM_LED; k++)
        begin : g_led
            always_ff @(posedge core_clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                    dis_reg[k] <= 1'b0;
                else if (state_reg == ldp_pkg::ST_CHECK && led_sense_i.shorted[k])
                    dis_reg[k] <= 1'b1;
            end

            always_ff @(posedge core_clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    en_reg[k]  <= 1'b0;
                    neg_reg[k] <= 1'b0;
                end
                else
                begin
                    en_reg[k]  <= run_ok && !dis_reg[k];
                    neg_reg[k] <= run_ok && !dis_reg[k]
                                  && led_sense_i.below_switchover[k];
                end
            end
        end
    endgenerate

    // charge pump request
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pump_reg <= 1'b0;
        else
            pump_reg <= run_ok && |(led_sense_i.below_switchover & ~dis_reg);
    end

    // dim pulse edge
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pulse_prev_reg <= 1'b0;
        else
            pulse_prev_reg <= dim_pulse_input_i;
    end

    // level index
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            level_reg <= ldp_pkg::LVL_RESET;
        else if (pulse_rise && level_reg >= ldp_pkg::LVL_LAST)
            level_reg <= ldp_pkg::LVL_RESET;
        else if (pulse_rise)
            level_reg <= level_reg + 5'h01;
    end

    // level to range and duty
    always_comb
    begin
        cfg_next.range_sel = ldp_pkg::RNG_DC;
        cfg_next.duty      = ldp_pkg::DUTY_FULL;
        if (level_reg < ldp_pkg::LVL_6P4 || level_reg > ldp_pkg::LVL_LAST)
        begin
            cfg_next.range_sel = ldp_pkg::RNG_DC;
            cfg_next.duty      = ldp_pkg::DUTY_FULL;
        end
        else if (level_reg < ldp_pkg::LVL_3P2)
        begin
            cfg_next.range_sel = ldp_pkg::RNG_6P4;
            cfg_next.duty      = ldp_pkg::DUTY_FULL - 4'(level_reg - ldp_pkg::LVL_6P4);
        end
        else if (level_reg < ldp_pkg::LVL_1P6)
        begin
            cfg_next.range_sel = ldp_pkg::RNG_3P2;
            cfg_next.duty      = ldp_pkg::DUTY_FULL - 4'(level_reg - ldp_pkg::LVL_3P2);
        end
        else if (level_reg < ldp_pkg::LVL_0P8)
        begin
            cfg_next.range_sel = ldp_pkg::RNG_1P6;
            cfg_next.duty      = ldp_pkg::DUTY_FULL - 4'(level_reg - ldp_pkg::LVL_1P6);
        end
        else
        begin
            cfg_next.range_sel = ldp_pkg::RNG_0P8;
            cfg_next.duty      = ldp_pkg::DUTY_FULL - 4'(level_reg - ldp_pkg::LVL_0P8);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cfg_reg <= '{range_sel: ldp_pkg::RNG_DC, duty: ldp_pkg::DUTY_FULL};
        else
            cfg_reg <= cfg_next;
    end

    // internal pwm
    ldp_pwm u_pwm
    (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .duty_i     (cfg_reg.duty),
        .pwm_o      (dim_pwm_o),
        .phase_o    ()
    );

    assign dim_cfg_o               = cfg_reg;
    assign led_current_level_o     = level_reg;
    assign led_sink_output_en_o    = en_reg;
    assign negative_rail_sel_o     = neg_reg;
    assign negative_rail_pump_en_o = pump_reg;
    assign short_check_done_o      = (state_reg != ldp_pkg::ST_CHECK);
    assign therm_shutdown_o        = (state_reg == ldp_pkg::ST_THERM);

    a_level_wrap : assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        pulse_rise && level_reg == ldp_pkg::LVL_LAST |=> level_reg == ldp_pkg::LVL_RESET)
        else $error("level did not wrap to full scale");
    a_level_step : assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        pulse_rise && level_reg < ldp_pkg::LVL_LAST |=> level_reg == $past(level_reg) + 5'h01)
        else $error("level did not step by one");
    a_short_disable : assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        state_reg == ldp_pkg::ST_CHECK && led_sense_i.shorted[0] |=> ##1 !en_reg[0])
        else $error("shorted output enabled after check");
    a_late_short : assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        state_reg != ldp_pkg::ST_CHECK |=> $stable(dis_reg))
        else $error("disable flags changed after startup");
    a_therm_off : assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        therm_hot_i |=> en_reg == '0 && !pump_reg)
        else $error("regulators on during thermal limit");
    a_therm_hyst : assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        state_reg == ldp_pkg::ST_THERM && !therm_cooled_i |=> state_reg == ldp_pkg::ST_THERM)
        else $error("left thermal shutdown before cooling");
    a_open_pump : assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        run_ok && |(led_sense_i.below_switchover & ~dis_reg) |=> pump_reg)
        else $error("open output did not start charge pump");
    a_range_low : assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        level_reg == ldp_pkg::LVL_LAST |=> cfg_reg.range_sel == ldp_pkg::RNG_0P8
        && cfg_reg.duty == 4'h1)
        else $error("lowest level not 0.8 range at one eighth");
    a_range_dc : assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        level_reg < ldp_pkg::LVL_6P4 |=> cfg_reg.range_sel == ldp_pkg::RNG_DC
        && cfg_reg.duty == ldp_pkg::DUTY_FULL)
        else $error("high level not dc only");
    c_check_done : cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
        state_reg == ldp_pkg::ST_CHECK ##1 state_reg == ldp_pkg::ST_RUN);
    c_therm_cycle : cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
        state_reg == ldp_pkg::ST_THERM ##1 state_reg == ldp_pkg::ST_RUN);
    c_wrap : cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
        pulse_rise && level_reg == ldp_pkg::LVL_LAST);
    c_pump : cover property (@(posedge core_clk_i) disable iff (!rst_n_i) pump_reg);
endmodule // ldp_top
`default_nettype wire

// ==== pkg/ldp_pkg.sv ====
// constants and carrier types for the low-current dimming pwm block
`default_nettype none
package ldp_pkg;
    // clock and pwm timing
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned PWM_FREQ_HZ   = 16_000;
    localparam int unsigned PWM_STEPS     = 8;
    localparam int unsigned PWM_TICK_CYC  = CLK_HZ / (PWM_FREQ_HZ * PWM_STEPS);
    // power-up short check window
    localparam int unsigned CHECK_TIME_US = 100;
    localparam int unsigned CHECK_CYC     = CHECK_TIME_US * (CLK_HZ / 1_000_000);
    // outputs and level table
    localparam int unsigned NUM_LED       = 6;
    localparam logic [4:0]  LVL_RESET     = 5'h00;
    localparam logic [4:0]  LVL_LAST      = 5'h1E;
    localparam logic [4:0]  LVL_6P4       = 5'h0B;
    localparam logic [4:0]  LVL_3P2       = 5'h0F;
    localparam logic [4:0]  LVL_1P6       = 5'h13;
    localparam logic [4:0]  LVL_0P8       = 5'h17;
    localparam logic [3:0]  DUTY_FULL     = 4'h8;

    // reference range selection
    typedef enum logic [2:0] {
        RNG_DC  = 3'h0,
        RNG_6P4 = 3'h1,
        RNG_3P2 = 3'h2,
        RNG_1P6 = 3'h3,
        RNG_0P8 = 3'h4
    } ldp_range_t;

    // reference range plus duty in eighths
    typedef struct packed {
        ldp_range_t range_sel;
        logic [3:0] duty;
    } ldp_dim_cfg_t;

    // per-output analog indications
    typedef struct packed {
        logic [NUM_LED-1:0] shorted;
        logic [NUM_LED-1:0] below_switchover;
    } ldp_led_sense_t;

    // supervisor states
    typedef enum logic [2:0] {
        ST_CHECK = 3'b001,
        ST_RUN   = 3'b010,
        ST_THERM = 3'b100
    } ldp_state_t;
endpackage
`default_nettype wire

// ==== rtl/ldp_pwm.sv ====
// internal dimming pwm: phase counter and duty compare
`timescale 1ns/1ps
`default_nettype none
module ldp_pwm
(
    // clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    // duty in eighths
    input  wire logic [3:0] duty_i,
    // pwm output
    output logic            pwm_o,
    output logic [2:0]      phase_o
);
    logic [6:0] tick_reg;
    logic [2:0] phase_reg;
    logic       pwm_reg;
    logic       tick;

    assign tick = (tick_reg == 7'(ldp_pkg::PWM_TICK_CYC - 1));

    // tick divider, eight ticks per period
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            tick_reg <= 7'h00;
        else if (tick)
            tick_reg <= 7'h00;
        else
            tick_reg <= tick_reg + 7'h01;
    end

    // phase counter
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            phase_reg <= 3'h0;
        else if (tick)
            phase_reg <= phase_reg + 3'h1;
    end

    // on while phase below n
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pwm_reg <= 1'b0;
        else
            pwm_reg <= ({1'b0, phase_reg} < duty_i);
    end

    assign pwm_o   = pwm_reg;
    assign phase_o = phase_reg;

    a_full_duty_on : assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        duty_i == ldp_pkg::DUTY_FULL |=> pwm_o)
        else $error("full duty did not hold pwm on");
    a_tick_period : assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        tick |-> ##78 tick)
        else $error("pwm tick period wrong");
    a_min_on_eighth : assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        duty_i == 4'h1 && phase_reg != 3'h0 |=> !pwm_o)
        else $error("one-eighth duty on outside first phase");
    c_pwm_wrap : cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
        tick && phase_reg == 3'h7);
endmodule // ldp_pwm
`default_nettype wire

// ==== verif/ldp_reg_model.sv ====
// behavioural model of the led strings and regulator sense comparators
`timescale 1ns/1ps
`default_nettype none
module ldp_reg_model
(
    // clock
    input  wire logic                        core_clk_i,
    // fault setup and pacing from the bench
    input  wire logic [ldp_pkg::NUM_LED-1:0] short_mask_i,
    input  wire logic [ldp_pkg::NUM_LED-1:0] open_mask_i,
    input  wire logic                        slow_i,
    // regulator enables from the block
    input  wire logic [ldp_pkg::NUM_LED-1:0] led_en_i,
    // sense back to the block
    output ldp_pkg::ldp_led_sense_t          led_sense_o
);
    ldp_pkg::ldp_led_sense_t now_sense;
    ldp_pkg::ldp_led_sense_t late_reg;
    // unused output tied to supply reads as shorted
    // open string drops below switchover only while driven
    assign now_sense = '{shorted: short_mask_i, below_switchover: open_mask_i & led_en_i};
    always_ff @(posedge core_clk_i)
    begin
        late_reg <= now_sense;
    end
    assign led_sense_o = slow_i ? late_reg : now_sense;
endmodule // ldp_reg_model
`default_nettype wire

// ==== verif/ldp_top_tb_top.sv ====
// self-checking bench for the low-current dimming block
`timescale 1ns/1ps
`default_nettype none
module ldp_top_tb_top;
    logic                    core_clk_i = 1'b0;
    logic                    rst_n_i = 1'b0;
    logic                    dim_pulse_input_i = 1'b0;
    logic                    therm_hot_i = 1'b0;
    logic                    therm_cooled_i = 1'b0;
    logic                    slow = 1'b0;
    logic [5:0]              short_mask = 6'h24;
    logic [5:0]              open_mask = 6'h00;
    logic [5:0]              exp_en = 6'h00;
    logic [31:0]             rnd = 32'h7B480DA9;
    ldp_pkg::ldp_led_sense_t led_sense;
    ldp_pkg::ldp_dim_cfg_t   dim_cfg;
    ldp_pkg::ldp_dim_cfg_t   cfg_exp;
    logic [4:0]              level;
    logic                    dim_pwm;
    logic [5:0]              led_en;
    logic [5:0]              neg_sel;
    logic                    pump_en;
    logic                    check_done;
    logic                    therm_sd;
    int                      n_mismatch = 0;
    int                      num_checks = 0;
    int                      cycles = 0;
    int                      lvl_model = 0;
    int                      hi_cnt;

    always #50 core_clk_i = ~core_clk_i;

    ldp_top ldp_top_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .dim_pulse_input_i(dim_pulse_input_i), .led_sense_i(led_sense),
        .therm_hot_i(therm_hot_i), .therm_cooled_i(therm_cooled_i), .dim_cfg_o(dim_cfg),
        .led_current_level_o(level), .dim_pwm_o(dim_pwm), .led_sink_output_en_o(led_en),
        .negative_rail_sel_o(neg_sel), .negative_rail_pump_en_o(pump_en),
        .short_check_done_o(check_done), .therm_shutdown_o(therm_sd));
    ldp_reg_model ldp_reg_model_inst (.core_clk_i(core_clk_i), .short_mask_i(short_mask),
        .open_mask_i(open_mask), .slow_i(slow), .led_en_i(led_en), .led_sense_o(led_sense));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    function automatic ldp_pkg::ldp_dim_cfg_t exp_cfg(input int lv);
        ldp_pkg::ldp_dim_cfg_t c;
        c.range_sel = ldp_pkg::RNG_DC;
        c.duty = 4'h8;
        if (lv >= 23)
        begin
            c.range_sel = ldp_pkg::RNG_0P8;
            c.duty = 4'(31 - lv);
        end
        else if (lv >= 11)
        begin
            c.range_sel = ldp_pkg::ldp_range_t'(3'(1 + (lv - 11) / 4));
            c.duty = 4'(8 - (lv - 11) % 4);
        end
        return c;
    endfunction

    task automatic finish_test();
        if (n_mismatch == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic chk_cfg(input string name, input ldp_pkg::ldp_dim_cfg_t exp,
                           input ldp_pkg::ldp_dim_cfg_t got);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic wait_chk(input int n);
        repeat (n) @(posedge core_clk_i);
        @(negedge core_clk_i);
    endtask

    task automatic do_reset();
        @(posedge core_clk_i);
        rst_n_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        lvl_model = 0;
        for (int i = 0; i < 1100 && check_done !== 1'b1; i++) @(negedge core_clk_i);
        wait_chk(2);
        exp_en = ~short_mask;
        chk_val("check_done", 16'h0001, 16'(check_done));
        chk_val("led_en", 16'(exp_en), 16'(led_en));
    endtask

    task automatic pulse();
        rnd = xs(rnd);
        @(posedge core_clk_i);
        dim_pulse_input_i <= 1'b1;
        repeat (1 + rnd[3:2]) @(posedge core_clk_i);
        dim_pulse_input_i <= 1'b0;
        lvl_model = (lvl_model == 30) ? 0 : lvl_model + 1;
        wait_chk(2 + rnd[1:0]);
        cfg_exp = exp_cfg(lvl_model);
        chk_val("level", 16'(lvl_model), 16'(level));
        chk_cfg("dim_cfg", cfg_exp, dim_cfg);
        hi_cnt = 0;
        repeat (ldp_pkg::PWM_STEPS * ldp_pkg::PWM_TICK_CYC)
        begin
            @(negedge core_clk_i);
            hi_cnt += (dim_pwm === 1'b1);
        end
        chk_val("pwm_high", 16'(cfg_exp.duty * ldp_pkg::PWM_TICK_CYC), 16'(hi_cnt));
    endtask

    always @(posedge core_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            n_mismatch++;
            finish_test();
        end
    end

    initial
    begin
        do_reset();
        repeat (32) pulse();
        @(posedge core_clk_i);
        short_mask <= 6'h25;
        wait_chk(4);
        chk_val("late_short", 16'(exp_en), 16'(led_en));
        repeat (6)
        begin
            rnd = xs(rnd);
            @(posedge core_clk_i);
            open_mask <= rnd[5:0];
            slow <= rnd[6];
            wait_chk(4);
            chk_val("neg_sel", 16'(open_mask & exp_en), 16'(neg_sel));
            chk_val("pump_en", 16'(|(open_mask & exp_en)), 16'(pump_en));
        end
        @(posedge core_clk_i);
        open_mask <= 6'h3F;
        therm_hot_i <= 1'b1;
        wait_chk(3);
        chk_val("therm_sd", 16'h0001, 16'(therm_sd));
        chk_val("en_hot", 16'h0000, 16'(led_en));
        chk_val("pump_hot", 16'h0000, 16'(pump_en));
        @(posedge core_clk_i);
        therm_cooled_i <= 1'b1;
        wait_chk(3);
        chk_val("sd_hot_cool", 16'h0001, 16'(therm_sd));
        @(posedge core_clk_i);
        therm_hot_i <= 1'b0;
        therm_cooled_i <= 1'b0;
        wait_chk(3);
        chk_val("sd_warm", 16'h0001, 16'(therm_sd));
        @(posedge core_clk_i);
        therm_cooled_i <= 1'b1;
        wait_chk(3);
        chk_val("sd_cooled", 16'h0000, 16'(therm_sd));
        chk_val("en_cooled", 16'(exp_en), 16'(led_en));
        @(posedge core_clk_i);
        therm_cooled_i <= 1'b0;
        slow <= 1'b1;
        do_reset();
        @(posedge core_clk_i);
        rst_n_i <= 1'b0;
        therm_hot_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        wait_chk(1003);
        chk_val("done_hot", 16'h0001, 16'(check_done));
        chk_val("sd_hot_check", 16'h0001, 16'(therm_sd));
        chk_val("en_hot_check", 16'h0000, 16'(led_en));
        finish_test();
    end
endmodule // ldp_top_tb_top
`default_nettype wire
